// ### common/hurx_defines.vh
// Constants for the host-facing receive queue with per-character error
// tracking. Included by the receive queue design file; holds definitions only.
`ifndef HURX_DEFINES_VH
`define HURX_DEFINES_VH

// Queue geometry: sixteen entries of one character plus three flags.
`define HURX_DEPTH 16
`define HURX_DATA_W 8
`define HURX_ERR_W 3
`define HURX_ADDR_W 4

// Positions of the error flags inside the shadow and each entry.
`define HURX_ERR_PARITY 0
`define HURX_ERR_FRAMING 1
`define HURX_ERR_BREAK 2

// Bit positions of the host line status byte.
`define HURX_LS_DATA_READY 0
`define HURX_LS_OVERRUN 1
`define HURX_LS_PARITY 2
`define HURX_LS_FRAMING 3
`define HURX_LS_BREAK 4
`define HURX_LS_FIFO_ERR 7

// Reset values.
`define HURX_SHADOW_RST 3'h0
`define HURX_LS_RST 8'h00
`define HURX_DATA_RST 8'h00

`endif

// ### core/hurx_store.v
// Flip-flop storage for the receive queue: one write port, one
// combinational read port. Assumes the caller never writes a full queue.
`timescale 1ns/10ps

module hurx_store #(
	parameter WIDTH = 11,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clock.
	input wire clock,
	// Write port.
	input wire wr_en,
	input wire [AW-1:0] wr_addr,
	input wire [WIDTH-1:0] wr_data,
	// Read port.
	input wire [AW-1:0] rd_addr,
	output wire [WIDTH-1:0] rd_data
);

	reg [WIDTH-1:0] mem_r [0:DEPTH-1];

	// Entries hold no control state, so they carry no reset.
	always @(posedge clock)
	begin
		if (wr_en)
		begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	// The head entry is read without delay.
	assign rd_data = mem_r[rd_addr];

endmodule // hurx_store

// ### core/hurx_rx_queue.v
// Receive queue of a host-facing UART emulation with error tracking.
// Assumes the local processor and the host strobes are synchronous to
// clock and last one cycle each.
//
// Contract
// [RULE_01] Sixteen entries: byte plus three error flags.
// [RULE_02] Entry flags copy write-only local shadow bits.
// [RULE_03] Shadow bits clear after copy into entry.
// [RULE_04] Local side writes status before its character.
// [RULE_05] Character write stores byte and shadow together.
// [RULE_06] Entry flags reach host only at head.
// [RULE_07] Host flags set from head, cleared by status read.
// [RULE_08] Flags accumulate over pops without status read.
// [RULE_09] Active-high host interrupt marks pending condition.
// [RULE_10] DMA mode: low ready while data available.
// [RULE_11] Empty read moves nothing and keeps flags.
`timescale 1ns/10ps
`include "hurx_defines.vh"

module hurx_rx_queue #(
	parameter DEPTH = `HURX_DEPTH,
	parameter AW = `HURX_ADDR_W
) (
	// Clock and reset.
	input wire clock,
	input wire rst,
	// Mode controls.
	input wire queue_mode_en,
	input wire dma_mode_en,
	input wire rx_data_irq_en,
	input wire line_status_irq_en,
	// Local processor side.
	input wire loc_status_wr,
	input wire [`HURX_ERR_W-1:0] loc_status_din,
	input wire loc_char_wr,
	input wire [`HURX_DATA_W-1:0] loc_char_din,
	output wire loc_queue_full,
	output wire [AW:0] loc_queue_level,
	// Host side.
	input wire host_rx_rd,
	output wire [`HURX_DATA_W-1:0] host_rx_data,
	input wire host_ls_rd,
	output wire [7:0] line_status_reg,
	output wire host_irq_out,
	output wire host_rx_ready_n
);

	localparam EW = `HURX_DATA_W + `HURX_ERR_W;
	localparam [AW:0] DEPTH_C = DEPTH;
	localparam [AW:0] ONE_C = 1;

	// Pointer advance with wrap at the queue depth.
	function [AW-1:0] ptr_inc;
		input [AW-1:0] p;
		begin
			if (p == DEPTH - 1)
				ptr_inc = {AW{1'b0}};
			else
				ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
		end
	endfunction

	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	reg [`HURX_ERR_W-1:0] shadow_r;
	reg [`HURX_ERR_W-1:0] host_err_r;
	reg [`HURX_ERR_W-1:0] host_err_nxt;
	reg overrun_r;
	reg head_taken_r;
	reg [`HURX_DATA_W-1:0] rx_data_r;
	reg [7:0] ls_data_r;
	reg irq_r;
	reg rx_ready_n_r;
	wire [EW-1:0] head_entry;
	wire [AW:0] capacity;
	wire queue_empty;
	wire push;
	wire pop;
	wire head_merge;

	// Outside queued mode the queue holds one character at a time.
	assign capacity = queue_mode_en ? DEPTH_C : ONE_C;
	assign queue_empty = (count_r == {(AW+1){1'b0}});
	assign loc_queue_full = (count_r >= capacity);
	assign loc_queue_level = count_r;
	// An empty queue ignores a host pop entirely.
	assign pop = host_rx_rd & ~queue_empty; // [RULE_11]
	assign push = loc_char_wr & ~loc_queue_full;
	// The head entry is merged into host flags once, when it arrives.
	assign head_merge = ~queue_empty & ~head_taken_r; // [RULE_06]

	// Byte and shadow flags go into the same slot on a character write.
	hurx_store #(
		.WIDTH(EW),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_store (
		.clock(clock),
		.wr_en(push), // [RULE_05]
		.wr_addr(wr_ptr_r),
		.wr_data({shadow_r, loc_char_din}), // [RULE_01]
		.rd_addr(rd_ptr_r),
		.rd_data(head_entry)
	);

	// Queue pointers and fill level.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			if (pop)
				rd_ptr_r <= ptr_inc(rd_ptr_r);
			if (push & ~pop)
				count_r <= count_r + ONE_C;
			else if (pop & ~push)
				count_r <= count_r - ONE_C;
		end
	end

	// Shadow flags: loaded by the local status write, cleared once copied.
	// A status write in the same cycle as a copy is the newer value and
	// wins, which suits a processor that writes status before the byte.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			shadow_r <= `HURX_SHADOW_RST;
		else if (loc_status_wr)
			shadow_r <= loc_status_din; // [RULE_02] [RULE_04]
		else if (push)
			shadow_r <= `HURX_SHADOW_RST; // [RULE_03]
	end

	// Tracks whether the current head has already been merged.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			head_taken_r <= 1'b0;
		else if (pop)
			head_taken_r <= 1'b0;
		else if (head_merge)
			head_taken_r <= 1'b1;
	end

	// Sticky host flags: a status read clears them, a head merge in the
	// same cycle sets them again so no error is lost.
	always @*
	begin
		host_err_nxt = host_err_r;
		if (host_ls_rd)
			host_err_nxt = {`HURX_ERR_W{1'b0}}; // [RULE_07]
		if (head_merge)
		begin
			host_err_nxt = host_err_nxt |
				head_entry[EW-1:`HURX_DATA_W]; // [RULE_07] [RULE_08]
		end
	end

	// Flag and overrun state.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			host_err_r <= {`HURX_ERR_W{1'b0}};
			overrun_r <= 1'b0;
		end
		else
		begin
			host_err_r <= host_err_nxt;
			if (loc_char_wr & loc_queue_full)
				overrun_r <= 1'b1;
			else if (host_ls_rd)
				overrun_r <= 1'b0;
		end
	end

	// Host data read: the head byte is latched on a non-empty pop.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			rx_data_r <= `HURX_DATA_RST;
		else if (pop)
			rx_data_r <= head_entry[`HURX_DATA_W-1:0];
	end

	// Line status snapshot taken on a host status read.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			ls_data_r <= `HURX_LS_RST;
		else if (host_ls_rd)
		begin
			ls_data_r <= `HURX_LS_RST;
			ls_data_r[`HURX_LS_DATA_READY] <= ~queue_empty;
			ls_data_r[`HURX_LS_OVERRUN] <= overrun_r;
			ls_data_r[`HURX_LS_PARITY] <=
				host_err_r[`HURX_ERR_PARITY]; // [RULE_06]
			ls_data_r[`HURX_LS_FRAMING] <=
				host_err_r[`HURX_ERR_FRAMING];
			ls_data_r[`HURX_LS_BREAK] <= host_err_r[`HURX_ERR_BREAK];
			ls_data_r[`HURX_LS_FIFO_ERR] <= |host_err_r;
		end
	end

	// Host interrupt and DMA receive ready, both from flip-flops.
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			irq_r <= 1'b0;
			rx_ready_n_r <= 1'b1;
		end
		else
		begin
			irq_r <= (line_status_irq_en &
				((|host_err_nxt) | overrun_r)) |
				(rx_data_irq_en & ~queue_empty); // [RULE_09] [RULE_06]
			rx_ready_n_r <= ~(dma_mode_en & ~queue_empty); // [RULE_10]
		end
	end

	assign host_rx_data = rx_data_r;
	assign line_status_reg = ls_data_r;
	assign host_irq_out = irq_r;
	assign host_rx_ready_n = rx_ready_n_r;

endmodule // hurx_rx_queue

// ### verification/hurx_properties.sv
// Assertions on the receive queue ports.
// Bound to every instance of the queue.
`timescale 1ns/10ps
module hurx_checker #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset.
	input logic clock,
	input logic rst,
	// Controls.
	input logic queue_mode_en,
	input logic dma_mode_en,
	input logic rx_data_irq_en,
	input logic line_status_irq_en,
	// Strobes.
	input logic loc_char_wr,
	input logic host_rx_rd,
	input logic host_ls_rd,
	// Results.
	input logic loc_queue_full,
	input logic [AW:0] loc_queue_level,
	input logic [7:0] host_rx_data,
	input logic [7:0] line_status_reg,
	input logic host_irq_out,
	input logic host_rx_ready_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Queue depth, pushes, empty pops and line status hold.
	a_full_at_depth:
		assert property (queue_mode_en && loc_queue_level == DEPTH
		|-> loc_queue_full) else $error("no full flag");
	a_push_counts:
		assert property (loc_char_wr && !loc_queue_full && !host_rx_rd
		|=> loc_queue_level == $past(loc_queue_level) + 1'b1)
		else $error("push not counted");
	a_empty_pop_still:
		assert property (host_rx_rd && loc_queue_level == 0 && !loc_char_wr
		|=> $stable(host_rx_data) && loc_queue_level == 0)
		else $error("empty pop moved queue");
	a_status_holds:
		assert property (!host_ls_rd |=> $stable(line_status_reg))
		else $error("status changed unread");
	// Host ready and interrupt pins.
	a_ready_low:
		assert property (dma_mode_en && loc_queue_level != 0
		|=> !host_rx_ready_n) else $error("ready not low");
	a_ready_off:
		assert property (!dma_mode_en |=> host_rx_ready_n)
		else $error("ready low outside dma");
	a_irq_on_data:
		assert property (rx_data_irq_en && loc_queue_level != 0
		|=> host_irq_out) else $error("no data irq");
	a_irq_quiet:
		assert property (!rx_data_irq_en && !line_status_irq_en
		|=> !host_irq_out) else $error("irq while disabled");
endmodule // hurx_checker

bind hurx_rx_queue hurx_checker #(.DEPTH(DEPTH), .AW(AW)) i_chk (
	.clock(clock), .rst(rst),
	.queue_mode_en(queue_mode_en), .dma_mode_en(dma_mode_en),
	.rx_data_irq_en(rx_data_irq_en),
	.line_status_irq_en(line_status_irq_en),
	.loc_char_wr(loc_char_wr), .host_rx_rd(host_rx_rd),
	.host_ls_rd(host_ls_rd), .loc_queue_full(loc_queue_full),
	.loc_queue_level(loc_queue_level), .host_rx_data(host_rx_data),
	.line_status_reg(line_status_reg), .host_irq_out(host_irq_out),
	.host_rx_ready_n(host_rx_ready_n)
);

// ### verification/hurx_host_model.sv
// Host side model issuing one-cycle pops and status reads.
// Assumes the bench calls its task after a clock edge.
`timescale 1ns/10ps
module hurx_host_model (
	// Clock.
	input logic clock,
	// Host strobes.
	output logic host_rx_rd,
	output logic host_ls_rd
);
	initial {host_rx_rd, host_ls_rd} = 2'h0;
	// Status reads wait for pending merges to land first.
	task automatic strobe(input logic ls);
		repeat (ls ? 3 : 1) @(posedge clock);
		#1;
		if (ls) host_ls_rd = 1'b1;
		else host_rx_rd = 1'b1;
		@(posedge clock) #1;
		{host_rx_rd, host_ls_rd} = 2'h0;
	endtask
endmodule // hurx_host_model

// ### verification/host_uart_rx_fifo_error_track_test.sv
// Self-checking bench for the receive queue.
// Uses the host model and the bound checker.
`timescale 1ns/10ps
module host_uart_rx_fifo_error_track_test;
	logic clock, rst, queue_mode_en, dma_mode_en, rx_data_irq_en;
	logic line_status_irq_en, loc_status_wr, loc_char_wr, host_rx_rd;
	logic host_ls_rd, loc_queue_full, host_irq_out, host_rx_ready_n;
	logic [2:0] loc_status_din;
	logic [7:0] loc_char_din, host_rx_data, line_status_reg;
	logic [4:0] loc_queue_level;
	int err_total, total_checks, i;
	hurx_rx_queue i_dut (
		.clock(clock), .rst(rst),
		.queue_mode_en(queue_mode_en), .dma_mode_en(dma_mode_en),
		.rx_data_irq_en(rx_data_irq_en),
		.line_status_irq_en(line_status_irq_en),
		.loc_status_wr(loc_status_wr), .loc_status_din(loc_status_din),
		.loc_char_wr(loc_char_wr), .loc_char_din(loc_char_din),
		.loc_queue_full(loc_queue_full),
		.loc_queue_level(loc_queue_level),
		.host_rx_rd(host_rx_rd), .host_rx_data(host_rx_data),
		.host_ls_rd(host_ls_rd), .line_status_reg(line_status_reg),
		.host_irq_out(host_irq_out), .host_rx_ready_n(host_rx_ready_n)
	);
	hurx_host_model i_host (
		.clock(clock),
		.host_rx_rd(host_rx_rd),
		.host_ls_rd(host_ls_rd)
	);
	// Clock.
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task chk(input string n, input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s exp %h got %h", n, e, g);
		end
	endtask
	task close_out;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Status first, then its character.
	task automatic push(logic [2:0] st, logic s, logic [7:0] c);
		@(posedge clock) #1;
		loc_status_wr = s;
		loc_status_din = st;
		@(posedge clock) #1;
		loc_status_wr = 1'b0;
		loc_char_wr = 1'b1;
		loc_char_din = c;
		@(posedge clock) #1;
		loc_char_wr = 1'b0;
	endtask
	task automatic t_reset;
		@(posedge clock) #1;
		chk("ls", line_status_reg, 8'h00);
		chk("rdy", host_rx_ready_n, 8'h01);
	endtask
	task automatic t_full;
		dma_mode_en = 1'b1;
		rx_data_irq_en = 1'b1;
		for (i = 0; i < 17; i++)
			push(3'h0, 1'b0, 8'h10 + i[7:0]);
		chk("lvl", loc_queue_level, 8'h10);
		chk("full", loc_queue_full, 8'h01);
		chk("irq", host_irq_out, 8'h01);
		chk("rdy", host_rx_ready_n, 8'h00);
		i_host.strobe(1'b1);
		chk("ovr", line_status_reg, 8'h03);
		for (i = 0; i < 17; i++)
		begin
			i_host.strobe(1'b0);
			chk("pop", host_rx_data, i < 16 ? 8'h10 + i[7:0] : 8'h1f);
		end
		chk("lvl", loc_queue_level, 8'h00);
		dma_mode_en = 1'b0;
		rx_data_irq_en = 1'b0;
	endtask
	task automatic t_errors;
		line_status_irq_en = 1'b1;
		push(3'h1, 1'b1, 8'h41);
		push(3'h2, 1'b1, 8'h42);
		push(3'h4, 1'b1, 8'h43);
		push(3'h0, 1'b0, 8'h44);
		chk("irq", host_irq_out, 8'h01);
		i_host.strobe(1'b1);
		chk("ls", line_status_reg, 8'h85);
		i_host.strobe(1'b1);
		chk("ls", line_status_reg, 8'h01);
		i_host.strobe(1'b0);
		chk("pop", host_rx_data, 8'h41);
		i_host.strobe(1'b0);
		i_host.strobe(1'b1);
		chk("ls", line_status_reg, 8'h99);
		i_host.strobe(1'b0);
		i_host.strobe(1'b0);
		i_host.strobe(1'b1);
		chk("ls", line_status_reg, 8'h00);
	endtask
	// Single-entry mode: the second byte is dropped as an overrun.
	task automatic t_single;
		queue_mode_en = 1'b0;
		push(3'h2, 1'b1, 8'h51);
		chk("lvl", loc_queue_level, 8'h01);
		chk("full", loc_queue_full, 8'h01);
		push(3'h0, 1'b0, 8'h52);
		i_host.strobe(1'b1);
		chk("ls", line_status_reg, 8'h8b);
		i_host.strobe(1'b0);
		chk("pop", host_rx_data, 8'h51);
		chk("lvl", loc_queue_level, 8'h00);
		chk("irq", host_irq_out, 8'h00);
		queue_mode_en = 1'b1;
	endtask
	// Main sequence.
	initial
	begin
		{dma_mode_en, rx_data_irq_en, line_status_irq_en} = 3'h0;
		{loc_status_wr, loc_char_wr, loc_status_din} = 5'h00;
		loc_char_din = 8'h00;
		queue_mode_en = 1'b1;
		rst = 1'b1;
		repeat (16) @(posedge clock);
		#1 rst = 1'b0;
		t_reset;
		t_full;
		t_errors;
		t_single;
		close_out;
	end
	// Watchdog.
	initial
	begin
		repeat (3000) @(posedge clock);
		err_total++;
		close_out;
	end
endmodule // host_uart_rx_fifo_error_track_test
